// ===== verilog/sdp_data_port.sv
// sdp_data_port: data and parity i/o path of a flow-through burst sram
// assumes: controller pins are synchronous to clk, oe_n and the strap are not;
// the core array answers core_rd_word combinationally for the sampled address
`timescale 1ns/1ps
`include "sdp_cfg.svh"

module sdp_data_port
  import sdp_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    resetn,
  // controller pins
  input  wire logic                    clock_qualifier_n,
  input  wire logic                    we_n,
  input  wire sdp_lanes_t              byte_lane_write_select_n,
  input  wire logic                    deselect,
  input  wire logic                    burst_adv,
  input  wire logic [`SDP_BURST_W-1:0] addr_lo,
  input  wire logic                    oe_n,
  input  wire logic                    burst_mode_strap,
  // data and parity lanes
  input  wire sdp_word_s               dq_in,
  output      sdp_word_s               dq_out,
  output      sdp_lanes_t              lane_oe,
  // core array side
  input  wire sdp_word_s               core_rd_word,
  output      logic                    core_wr_en,
  output      sdp_word_s               core_wr_word,
  output      sdp_lanes_t              core_wr_lane_en,
  output      logic [`SDP_BURST_W-1:0] burst_addr,
  output      logic                    read_phase
);

  // ----------------------------------------------------------------
  // synchronisers for asynchronous inputs
  // ----------------------------------------------------------------
  logic oe_n_meta_reg;
  logic oe_n_sync_reg;
  logic strap_meta_reg;
  logic strap_sync_reg;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      oe_n_meta_reg  <= `SDP_RST_HIGH;
      oe_n_sync_reg  <= `SDP_RST_HIGH;
      strap_meta_reg <= `SDP_RST_HIGH;
      strap_sync_reg <= `SDP_RST_HIGH;
    end else begin
      oe_n_meta_reg  <= oe_n;
      oe_n_sync_reg  <= oe_n_meta_reg;
      strap_meta_reg <= burst_mode_strap;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // cycle state
  // ----------------------------------------------------------------
  logic       qual;
  logic       wr_phase_reg;
  logic       wr_phase_next;
  logic       rd_phase_reg;
  logic       rd_phase_next;
  logic       desel_reg;
  logic       desel_next;
  logic       emerge_reg;
  logic       emerge_next;
  sdp_lanes_t bw_reg;
  sdp_lanes_t bw_next;
  logic       wr_en_reg;
  logic       wr_en_next;
  sdp_word_s  wr_word_reg;
  sdp_word_s  wr_word_next;
  sdp_lanes_t lane_en_reg;
  sdp_lanes_t lane_en_next;
  logic       drive;

  assign qual = !clock_qualifier_n;

  always_comb begin
    wr_phase_next = wr_phase_reg;
    rd_phase_next = rd_phase_reg;
    desel_next    = desel_reg;
    emerge_next   = emerge_reg;
    bw_next       = bw_reg;
    wr_word_next  = wr_word_reg;
    lane_en_next  = lane_en_reg;
    wr_en_next    = qual && wr_phase_reg;
    if (qual) begin
      desel_next    = deselect;
      emerge_next   = desel_reg && !deselect;
      wr_phase_next = !deselect && !we_n;
      rd_phase_next = !deselect && we_n;
      bw_next       = byte_lane_write_select_n;
      if (wr_phase_reg) begin
        wr_word_next = dq_in;
        lane_en_next = ~bw_reg;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_phase_reg <= `SDP_RST_LOW;
      rd_phase_reg <= `SDP_RST_LOW;
      desel_reg    <= `SDP_RST_HIGH;
      emerge_reg   <= `SDP_RST_LOW;
      bw_reg       <= `SDP_RST_LANES;
      wr_en_reg    <= `SDP_RST_LOW;
      wr_word_reg  <= '{par: `SDP_RST_LANES, dat: `SDP_RST_DATA};
      lane_en_reg  <= `SDP_RST_LANES;
    end else begin
      wr_phase_reg <= wr_phase_next;
      rd_phase_reg <= rd_phase_next;
      desel_reg    <= desel_next;
      emerge_reg   <= emerge_next;
      bw_reg       <= bw_next;
      wr_en_reg    <= wr_en_next;
      wr_word_reg  <= wr_word_next;
      lane_en_reg  <= lane_en_next;
    end
  end

  // ----------------------------------------------------------------
  // output drive, one enable per lane covers data and parity
  // ----------------------------------------------------------------
  assign drive = !oe_n_sync_reg && rd_phase_reg && !wr_phase_reg
              && !desel_reg && !emerge_reg;

  for (genvar i = 0; i < `SDP_LANES; i++) begin : g_lane
    assign lane_oe[i]         = drive;
    assign core_wr_lane_en[i] = lane_en_reg[i] && wr_en_reg;
  end

  assign dq_out       = core_rd_word;
  assign core_wr_en   = wr_en_reg;
  assign core_wr_word = wr_word_reg;
  assign read_phase   = rd_phase_reg;

  // ----------------------------------------------------------------
  // burst counter
  // ----------------------------------------------------------------
  sdp_burst_ctr u_burst (
    .clk         (clk),
    .resetn      (resetn),
    .qual        (qual),
    .load        (!deselect && !burst_adv),
    .advance     (!deselect && burst_adv),
    .interleaved (strap_sync_reg),
    .seed        (addr_lo),
    .burst_addr  (burst_addr)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  wr_capture_a: assert property (qual && wr_phase_reg |=>
    core_wr_en && core_wr_word == $past(dq_in)) else $error("write data not captured");
  rd_pass_a: assert property (|lane_oe |-> read_phase && dq_out == core_rd_word)
    else $error("read data not passed through");
  oe_drive_a: assert property (!$past(oe_n, 2) && !$past(oe_n) && rd_phase_reg
    && !emerge_reg && !wr_phase_reg |-> &lane_oe) else $error("lanes not driven");
  oe_release_a: assert property ($past(oe_n, 2)
    |-> lane_oe == '0) else $error("lanes driven with oe high");
  write_tri_a: assert property (qual && !deselect && !we_n |=> lane_oe == '0)
    else $error("lanes driven in write data phase");
  emerge_tri_a: assert property (qual && desel_reg && !deselect |=>
    lane_oe == '0) else $error("lanes driven on first clock after deselect");
  lane_mask_a: assert property (qual && wr_phase_reg |=>
    core_wr_lane_en == ~$past(bw_reg)) else $error("lane write mask wrong");
  hold_state_a: assert property (clock_qualifier_n |=> $stable(wr_phase_reg)
    && $stable(rd_phase_reg) && $stable(burst_addr) && !core_wr_en)
    else $error("state moved without qualifier");
  linear_step_a: assert property (qual && !deselect && burst_adv
    && !strap_sync_reg && $stable(strap_sync_reg) |=>
    burst_addr == $past(burst_addr) + `SDP_BURST_ONE) else $error("linear step wrong");
  burst_seed_a: assert property (qual && !deselect && !burst_adv |=>
    burst_addr == $past(addr_lo)) else $error("burst seed not loaded");
  desel_tri_a: assert property (desel_reg |-> lane_oe == '0)
    else $error("lanes driven while deselected");
  hold_word_a: assert property (clock_qualifier_n |=> $stable(core_wr_word))
    else $error("write word moved without qualifier");
  stall_oe_a: assert property (clock_qualifier_n |=> $stable(lane_oe)
    || $changed(oe_n_sync_reg)) else $error("lane drive moved without qualifier");
  wr_only_a: assert property (core_wr_en |-> $past(wr_phase_reg)
    && !$past(clock_qualifier_n)) else $error("write pulse without qualified data edge");
  wr_mask_idle_a: assert property (!core_wr_en |-> core_wr_lane_en == '0)
    else $error("lane write enable without write pulse");

  // ----------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------
  read_cov_c: cover property (qual && !deselect && we_n ##1 |lane_oe);
  write_cov_c: cover property (qual && !deselect && !we_n ##1 qual ##1 core_wr_en);
  stall_cov_c: cover property (wr_phase_reg && clock_qualifier_n ##1 qual ##1 core_wr_en);
  emerge_cov_c: cover property (desel_reg && qual && !deselect && we_n);
  burst_cov_c: cover property (qual && !deselect && burst_adv && strap_sync_reg ##1 qual);

endmodule : sdp_data_port

// ===== verilog/sdp_cfg.svh
// sdp_cfg.svh: constants of the sram data port
// assumes: included by bare name wherever the data port is built
`ifndef SDP_CFG_SVH
`define SDP_CFG_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define SDP_LANES      4
`define SDP_LANE_W     8
`define SDP_DATA_W     32
`define SDP_BURST_W    2

// ----------------------------------------------------------------
// reset values and burst step
// ----------------------------------------------------------------
`define SDP_RST_LOW    1'b0
`define SDP_RST_HIGH   1'b1
`define SDP_RST_BURST  2'h0
`define SDP_RST_LANES  4'h0
`define SDP_RST_DATA   32'h0000_0000
`define SDP_BURST_ONE  2'h1

`endif

// ===== verilog/sdp_pkg.sv
// sdp_pkg: types of the sram data port
// assumes: sdp_cfg.svh is on the include path
`include "sdp_cfg.svh"

package sdp_pkg;

  // ----------------------------------------------------------------
  // one bus word: data plus one parity bit per byte lane
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`SDP_LANES-1:0]  par;
    logic [`SDP_DATA_W-1:0] dat;
  } sdp_word_s;

  typedef logic [`SDP_LANES-1:0] sdp_lanes_t;

endpackage : sdp_pkg

// ===== verilog/sdp_burst_ctr.sv
// sdp_burst_ctr: two-bit burst counter, linear or interleaved order
// assumes: load, advance and qual come from logic on clk
`timescale 1ns/1ps
`include "sdp_cfg.svh"

module sdp_burst_ctr
  import sdp_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    resetn,
  // control
  input  wire logic                    qual,
  input  wire logic                    load,
  input  wire logic                    advance,
  input  wire logic                    interleaved,
  input  wire logic [`SDP_BURST_W-1:0] seed,
  // burst address
  output      logic [`SDP_BURST_W-1:0] burst_addr
);

  logic [`SDP_BURST_W-1:0] seed_reg;
  logic [`SDP_BURST_W-1:0] seed_next;
  logic [`SDP_BURST_W-1:0] step_reg;
  logic [`SDP_BURST_W-1:0] step_next;

  always_comb begin
    seed_next = seed_reg;
    step_next = step_reg;
    if (qual && load) begin
      seed_next = seed;
      step_next = `SDP_RST_BURST;
    end else if (qual && advance) begin
      step_next = step_reg + `SDP_BURST_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      seed_reg <= `SDP_RST_BURST;
      step_reg <= `SDP_RST_BURST;
    end else begin
      seed_reg <= seed_next;
      step_reg <= step_next;
    end
  end

  // interleaved order flips bits, linear order adds with wrap
  assign burst_addr = interleaved ? (seed_reg ^ step_reg)
                                  : (seed_reg + step_reg);

endmodule : sdp_burst_ctr

// ===== verif/sdp_ctrl_model.sv
// sdp_ctrl_model: controller side of the data and parity lanes
// assumes: drive and wdata change just after clk rises
`timescale 1ns/1ps

module sdp_ctrl_model
  import sdp_pkg::*;
(
  // clock
  input  wire logic       clk,
  // controller side
  input  wire logic       drive,
  input  wire sdp_word_s  wdata,
  // device side
  input  wire sdp_lanes_t lane_oe,
  input  wire sdp_word_s  dq_out,
  output      sdp_word_s  dq_in
);
  // ----------------------------------------------------------------
  // wire level
  // ----------------------------------------------------------------
  sdp_word_s last_reg = '0;

  always_ff @(posedge clk) begin
    if (lane_oe != '0 || drive) begin
      last_reg <= dq_in;
    end
  end

  // released lanes show the inverse of the last driven level
  always_comb begin
    dq_in = ~last_reg;
    if (lane_oe != '0) begin
      dq_in = dq_out;
    end else if (drive) begin
      dq_in = wdata;
    end
  end
endmodule : sdp_ctrl_model

// ===== verif/sdp_data_port_test.sv
// sdp_data_port_test: self-checking bench of the sram data port
// assumes: sdp_pkg compiled first; core array stands in as random read words
`timescale 1ns/1ps
`include "sdp_cfg.svh"

module sdp_data_port_test
  import sdp_pkg::*;
;
  typedef struct packed {sdp_word_s w; sdp_lanes_t l;} sdp_note_s;
  logic       clk = 0, resetn = 0, qn = 0, we_n = 1, des = 1, adv = 0;
  logic       oe_n = 0, strap = 0, drive = 0, core_wr_en, read_phase;
  logic [1:0] addr_lo = 0, next_a = 0, burst_addr, e;
  sdp_lanes_t sel_n = '1, lane_oe, core_wr_lane_en;
  sdp_word_s  wdata = '0, next_wd = '0, core_rd = '0, dq_in, dq_out, core_wr_word;
  sdp_note_s  notes[$];
  sdp_note_s  note;
  int         n_mismatch = 0, checks = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  sdp_data_port dut (.clk(clk), .resetn(resetn), .clock_qualifier_n(qn), .we_n(we_n),
    .byte_lane_write_select_n(sel_n), .deselect(des), .burst_adv(adv), .addr_lo(addr_lo),
    .oe_n(oe_n), .burst_mode_strap(strap), .dq_in(dq_in), .dq_out(dq_out), .lane_oe(lane_oe),
    .core_rd_word(core_rd), .core_wr_en(core_wr_en), .core_wr_word(core_wr_word),
    .core_wr_lane_en(core_wr_lane_en), .burst_addr(burst_addr), .read_phase(read_phase));

  sdp_ctrl_model u_ctrl (.clk(clk), .drive(drive), .wdata(wdata), .lane_oe(lane_oe),
    .dq_out(dq_out), .dq_in(dq_in));

  // ----------------------------------------------------------------
  // compare and drive
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  task automatic cmp_word(input string what, input sdp_word_s x, input sdp_word_s got);
    checks++;
    if (got !== x) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, x, got);
    end
  endtask : cmp_word

  task automatic cmp_small(input string what, input logic [3:0] x, input logic [3:0] got);
    checks++;
    if (got !== x) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, x, got);
    end
  endtask : cmp_small

  task automatic step(input logic q, w, d, a, input sdp_lanes_t s, input logic v);
    @(posedge clk);
    qn <= q;
    we_n <= w;
    des <= d;
    adv <= a;
    sel_n <= s;
    drive <= v;
    wdata <= next_wd;
    addr_lo <= next_a;
    core_rd <= 36'({$urandom(), $urandom()});
    #1;
  endtask : step

  task automatic chk_rd(input sdp_lanes_t x, input logic r);
    cmp_small("lane_oe", x, lane_oe);
    cmp_small("read_phase", {3'b000, r}, {3'b000, read_phase});
    if (x != '0) cmp_word("dq_out", core_rd, dq_out);
  endtask : chk_rd

  task automatic do_write(input logic stall);
    sdp_lanes_t s;
    s = 4'($urandom());
    next_wd = 36'({$urandom(), $urandom()});
    notes.push_back('{next_wd, ~s});
    step(0, 0, 0, 0, s, 0);
    if (stall) step(1, 1, 0, 0, '1, 1);
    step(0, 1, 0, 0, '1, 1);
    chk_rd(4'h0, 1'b0);
    step(0, 1, 0, 0, '1, 0);
    chk_rd(4'hf, 1'b1);
  endtask : do_write

  always @(posedge clk) begin
    if (core_wr_en === 1'b1) begin
      note = notes.pop_front();
      cmp_word("core_wr_word", note.w, core_wr_word);
      cmp_small("core_wr_lane_en", note.l, core_wr_lane_en);
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(95080));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      step(0, 1, i < 2, 0, '1, 0);
      if (i > 0) chk_rd(i < 4 ? 4'h0 : 4'hf, i > 2);
    end
    for (int i = 0; i < 6; i++) do_write(i % 2);
    oe_n <= 1'b1;
    repeat (4) step(0, 1, 0, 0, '1, 0);
    chk_rd(4'h0, 1'b1);
    oe_n <= 1'b0;
    repeat (4) step(0, 1, 0, 0, '1, 0);
    chk_rd(4'hf, 1'b1);
    for (int m = 0; m < 2; m++) begin
      strap <= m[0];
      next_a = 2'($urandom());
      repeat (4) step(0, 1, 0, 0, '1, 0);
      for (int s = 0; s < 4; s++) begin
        step(0, 1, 0, 1, '1, 0);
        e = m ? next_a ^ 2'(s) : next_a + 2'(s);
        cmp_small("burst_addr", {2'b00, e}, {2'b00, burst_addr});
      end
    end
    step(0, 1, 0, 0, '1, 0);
    cmp_small("pending", 4'h0, 4'(notes.size()));
    give_verdict();
  end

  initial begin
    #5000;
    n_mismatch++;
    give_verdict();
  end
endmodule : sdp_data_port_test
